//--- hw/tcu_params.svh
// constants for the timer/counter block: field widths and reset values
// assumes a single 20 MHz clock domain
`ifndef TCU_PARAMS_SVH
`define TCU_PARAMS_SVH
`define TCU_CW 32
`define TCU_PW 8
`define TCU_PSCW 10
`define TCU_CH 2
`define TCU_MAX8 32'h0000_00ff
`define TCU_MAX16 32'h0000_ffff
`define TCU_MAX32 32'hffff_ffff
`define TCU_PER_RST 8'hff
`define TCU_ZERO32 32'h0000_0000
`define TCU_PSC_ONE 10'h001
`endif

//--- hw/tcu_pkg.sv
// types for the timer/counter block
// assumes tcu_params.svh is on the include path
`default_nettype none
package tcu_pkg;
    typedef enum logic [1:0] {TCU_W16, TCU_W8, TCU_W32} tcu_width_e;
    typedef enum logic [1:0] {TCU_NFRQ, TCU_MFRQ, TCU_NPWM} tcu_wave_e;
    // enable-protected setup, latched only while disabled
    typedef struct packed {
        tcu_width_e counter_width_select;
        tcu_wave_e wave;
        logic count_down;
        logic clk_evt;
        logic [2:0] psc;
        logic [1:0] cap_en;
        logic [1:0] cap_evt;
        logic [1:0] cap_fall;
    } tcu_cfg_s;
    // per-source enables for dma, interrupt and output event
    typedef struct packed {
        logic dma;
        logic irq;
        logic evt;
    } tcu_req_s;
    typedef struct packed {
        tcu_cfg_s cfg;
        logic [31:0] cnt;
        logic [1:0][31:0] ccv;
        logic [1:0][31:0] ccb;
        logic [1:0] buffer_valid_flag;
        logic [7:0] period_value;
        logic [7:0] perb;
        logic perbv;
        logic [9:0] psc_cnt;
        logic upd;
        logic [1:0] mc;
        tcu_req_s ovf_req;
        logic [1:0][2:0] mc_req;
        logic [1:0] wave;
        logic [1:0] pin_q;
        logic [1:0] cap;
    } tcu_state_s;
endpackage
`default_nettype wire

//--- hw/tcu_top.sv
// timer/counter with prescaler, 8/16/32-bit counter, two compare/capture
// channels with buffers; assumes all inputs synchronous to clk_i
`include "tcu_params.svh"
`default_nettype none
// How it works
// - counter steps on input events or prescaled generic clock ticks
// - counter and channel registers act as 8, 16 or 32 bits wide
// - zero means all bits clear, max means all selected bits set
// - update signalled at top counting up or at zero counting down
// - direction selectable; count compared against top or zero limit
// - top/zero limit can raise dma request, interrupt or output event
// - two channels, each used as compare or as capture
// - each channel buffer has a valid flag set when written
// - in 8-bit width, except in match-frequency, a double-buffered period register sets top
// - compare match raises dma request, interrupt or event if enabled
// - waveform modes: frequency generation and single-slope pwm
// - capture latches count on pin edges or internal event
// - protected setup written only while the timer is disabled
module tcu_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // control
    input wire logic enable_i,
    input wire logic cfg_wr_i,
    input wire tcu_pkg::tcu_cfg_s cfg_i,
    input wire tcu_pkg::tcu_req_s ovf_en_i,
    input wire tcu_pkg::tcu_req_s mc0_en_i,
    input wire tcu_pkg::tcu_req_s mc1_en_i,
    // buffer writes
    input wire logic [1:0] ccb_wr_i,
    input wire logic [31:0] ccb_data_i,
    input wire logic perb_wr_i,
    input wire logic [7:0] perb_data_i,
    // clock and event sources
    input wire logic gclk_tick_i,
    input wire logic count_evt_i,
    input wire logic cap_evt_i,
    input wire logic [1:0] cap_pin_i,
    // state
    output logic [31:0] count_o,
    output logic [31:0] cc0_o,
    output logic [31:0] cc1_o,
    output logic [1:0] buffer_valid_flag_o,
    output logic [7:0] period_value_o,
    output logic period_valid_o,
    output logic [1:0] wave_o,
    // requests, one-cycle pulses
    output tcu_pkg::tcu_req_s ovf_req_o,
    output tcu_pkg::tcu_req_s mc0_req_o,
    output tcu_pkg::tcu_req_s mc1_req_o,
    output logic [1:0] capture_o
);
    tcu_pkg::tcu_state_s st_r;
    tcu_pkg::tcu_state_s st_nxt;
    logic en_r;

    function automatic logic [31:0] width_max(tcu_pkg::tcu_width_e w);
        if (w == tcu_pkg::TCU_W8)
            width_max = `TCU_MAX8;
        else if (w == tcu_pkg::TCU_W16)
            width_max = `TCU_MAX16;
        else
            width_max = `TCU_MAX32;
    endfunction

    logic [31:0] max_v;
    logic [31:0] top_v;
    logic [9:0] psc_mask;
    logic tick;
    logic at_top;
    logic at_zero;
    logic [1:0] edge_seen;
    logic [1:0] match;

    always_comb
    begin
        max_v = width_max(st_r.cfg.counter_width_select);
        psc_mask = 10'((`TCU_PSC_ONE << st_r.cfg.psc) - `TCU_PSC_ONE);
        // top: cc0 in match-frequency, period in 8-bit, otherwise max
        if (st_r.cfg.wave == tcu_pkg::TCU_MFRQ)
            top_v = st_r.ccv[0] & max_v;
        else if (st_r.cfg.counter_width_select == tcu_pkg::TCU_W8)
            top_v = {24'h00_0000, st_r.period_value};
        else
            top_v = max_v;
        tick = en_r & (st_r.cfg.clk_evt ? count_evt_i :
            (gclk_tick_i & ((st_r.psc_cnt & psc_mask) == psc_mask)));
        at_top = (st_r.cnt == top_v);
        at_zero = (st_r.cnt == `TCU_ZERO32);
        for (int i = 0; i < `TCU_CH; i++)
        begin
            edge_seen[i] = st_r.cfg.cap_evt[i] ? cap_evt_i :
                (st_r.cfg.cap_fall[i] ? (st_r.pin_q[i] & ~cap_pin_i[i]) :
                (~st_r.pin_q[i] & cap_pin_i[i]));
            match[i] = tick & ~st_r.cfg.cap_en[i] &
                (st_r.cnt == (st_r.ccv[i] & max_v));
        end
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.upd = 1'b0;
        st_nxt.mc = 2'h0;
        // capture pulse has its own flop so capture_o needs no gating
        st_nxt.cap = 2'h0;
        st_nxt.pin_q = cap_pin_i;
        if (cfg_wr_i && !en_r)
            st_nxt.cfg = cfg_i;
        // prescaler holds while disabled, so a new divide starts mid-count
        if (en_r && !st_r.cfg.clk_evt && gclk_tick_i)
            st_nxt.psc_cnt = st_r.psc_cnt + `TCU_PSC_ONE;
        if (tick)
        begin
            if (!st_r.cfg.count_down)
            begin
                st_nxt.cnt = at_top ? `TCU_ZERO32 :
                    ((st_r.cnt + 32'h0000_0001) & max_v);
                st_nxt.upd = at_top;
            end
            else
            begin
                st_nxt.cnt = at_zero ? top_v : (st_r.cnt - 32'h0000_0001);
                st_nxt.upd = at_zero;
            end
        end
        // copy before the buffer write so a fresh write keeps its flag
        if (st_nxt.upd)
        begin
            for (int i = 0; i < `TCU_CH; i++)
                if (st_r.buffer_valid_flag[i] && !st_r.cfg.cap_en[i])
                begin
                    st_nxt.ccv[i] = st_r.ccb[i];
                    st_nxt.buffer_valid_flag[i] = 1'b0;
                end
            if (st_r.perbv)
            begin
                st_nxt.period_value = st_r.perb;
                st_nxt.perbv = 1'b0;
            end
        end
        for (int i = 0; i < `TCU_CH; i++)
        begin
            if (en_r && st_r.cfg.cap_en[i] && edge_seen[i])
            begin
                st_nxt.ccv[i] = st_r.cnt & max_v;
                st_nxt.mc[i] = 1'b1;
                st_nxt.cap[i] = 1'b1;
            end
            else if (match[i])
                st_nxt.mc[i] = 1'b1;
            if (ccb_wr_i[i])
            begin
                st_nxt.ccb[i] = ccb_data_i & max_v;
                st_nxt.buffer_valid_flag[i] = 1'b1;
            end
        end
        if (perb_wr_i)
        begin
            st_nxt.perb = perb_data_i;
            st_nxt.perbv = 1'b1;
        end
        st_nxt.ovf_req = st_nxt.upd ? ovf_en_i : 3'h0;
        st_nxt.mc_req[0] = st_nxt.mc[0] ? mc0_en_i : 3'h0;
        st_nxt.mc_req[1] = st_nxt.mc[1] ? mc1_en_i : 3'h0;
        // waveform on channel outputs
        for (int i = 0; i < `TCU_CH; i++)
        begin
            if (st_r.cfg.wave == tcu_pkg::TCU_NPWM)
                st_nxt.wave[i] = en_r &
                    (st_nxt.cnt < (st_nxt.ccv[i] & max_v));
            else if (st_r.cfg.wave == tcu_pkg::TCU_MFRQ)
                st_nxt.wave[i] = st_r.wave[i] ^ (i == 0 && st_nxt.upd);
            else
                st_nxt.wave[i] = st_r.wave[i] ^ match[i];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            st_r <= '0;
            st_r.period_value <= `TCU_PER_RST;
            st_r.perb <= `TCU_PER_RST;
            en_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            en_r <= enable_i;
        end
    end

    assign count_o = st_r.cnt;
    assign cc0_o = st_r.ccv[0];
    assign cc1_o = st_r.ccv[1];
    assign buffer_valid_flag_o = st_r.buffer_valid_flag;
    assign period_value_o = st_r.period_value;
    assign period_valid_o = st_r.perbv;
    assign wave_o = st_r.wave;
    assign ovf_req_o = st_r.ovf_req;
    assign mc0_req_o = st_r.mc_req[0];
    assign mc1_req_o = st_r.mc_req[1];
    assign capture_o = st_r.cap;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_wrap_up;
        tick && !st_r.cfg.count_down && at_top;
    endsequence
    sequence s_wrap_seen;
        st_r.upd && st_r.cnt == `TCU_ZERO32;
    endsequence

    a_up_wrap_update: assert property (
        s_wrap_up |=> s_wrap_seen)
        else $error("counting up past top did not wrap with update");
    a_down_reload: assert property (
        tick && st_r.cfg.count_down && at_zero |=>
        st_r.upd && st_r.cnt == $past(top_v))
        else $error("counting down at zero did not reload top");
    a_ovf_request: assert property (
        st_r.upd |-> st_r.ovf_req == $past(ovf_en_i))
        else $error("overflow request not gated by its enables");
    a_count_width: assert property (
        st_r.cnt <= width_max(st_r.cfg.counter_width_select) ||
        $changed(st_r.cfg))
        else $error("counter exceeds selected width");
    a_idle_frozen: assert property (
        !en_r && !$past(en_r) |-> $stable(st_r.cnt))
        else $error("counter moved while disabled");
    a_cfg_locked: assert property (
        en_r |=> $stable(st_r.cfg))
        else $error("protected setup changed while enabled");
    a_buffer_valid_flag_set: assert property (
        ccb_wr_i[0] |=> st_r.buffer_valid_flag[0] ##1 1'b1)
        else $error("buffer valid flag not set after write");
    a_buf_copy: assert property (
        st_nxt.upd && st_r.buffer_valid_flag[1] && !st_r.cfg.cap_en[1] && !ccb_wr_i[1]
        |=> !st_r.buffer_valid_flag[1] && st_r.ccv[1] == $past(st_r.ccb[1]))
        else $error("buffered compare not moved on update");
    a_cmp_match: assert property (
        match[0] |=> st_r.mc[0] && st_r.mc_req[0] == $past(mc0_en_i))
        else $error("compare match not flagged");
    a_capture_latch: assert property (
        en_r && st_r.cfg.cap_en[1] && edge_seen[1] |=>
        st_r.ccv[1] == ($past(st_r.cnt) & $past(max_v)) && capture_o[1])
        else $error("capture did not latch the count");
    a_pwm_level: assert property (
        en_r && $past(en_r) && st_r.cfg.wave == tcu_pkg::TCU_NPWM &&
        $past(st_r.cfg.wave) == tcu_pkg::TCU_NPWM |->
        st_r.wave[0] == (st_r.cnt < (st_r.ccv[0] & $past(max_v))))
        else $error("pwm level disagrees with compare");

    // single steps between the limits, both directions
    sequence s_step_up;
        tick && !st_r.cfg.count_down && !at_top;
    endsequence
    sequence s_step_down;
        tick && st_r.cfg.count_down && !at_zero;
    endsequence

    a_up_step: assert property (
        s_step_up |=>
        st_r.cnt == (($past(st_r.cnt) + 32'h0000_0001) & $past(max_v)))
        else $error("counting up did not advance by one");
    a_down_step: assert property (
        s_step_down |=> st_r.cnt == ($past(st_r.cnt) - 32'h0000_0001))
        else $error("counting down did not step back by one");
    a_cfg_take: assert property (
        cfg_wr_i && !en_r |=> st_r.cfg == $past(cfg_i))
        else $error("setup write while disabled was not taken");
    a_per_copy: assert property (
        st_nxt.upd && st_r.perbv && !perb_wr_i |=>
        !st_r.perbv && st_r.period_value == $past(st_r.perb))
        else $error("buffered period not moved on update");
    a_perbv_set: assert property (
        perb_wr_i |=> st_r.perbv && st_r.perb == $past(perb_data_i))
        else $error("period buffer write not flagged");
    a_bufv1_set: assert property (
        ccb_wr_i[1] |=> st_r.buffer_valid_flag[1] &&
        st_r.ccb[1] == ($past(ccb_data_i) & $past(max_v)))
        else $error("channel one buffer write not flagged");
    a_mfrq_toggle: assert property (
        st_r.cfg.wave == tcu_pkg::TCU_MFRQ && st_nxt.upd |=>
        st_r.wave[0] != $past(st_r.wave[0]))
        else $error("frequency output did not toggle on update");
    a_nfrq_toggle: assert property (
        st_r.cfg.wave == tcu_pkg::TCU_NFRQ && match[0] |=>
        st_r.wave[0] != $past(st_r.wave[0]))
        else $error("match output did not toggle on compare");
    a_evt_capture: assert property (
        en_r && st_r.cfg.cap_en[1] && st_r.cfg.cap_evt[1] && cap_evt_i |=>
        capture_o[1] && st_r.mc_req[1] == $past(mc1_en_i))
        else $error("capture event did not raise capture request");
    a_ovf_only_upd: assert property (
        |st_r.ovf_req |-> st_r.upd)
        else $error("overflow request without an update");
endmodule
`default_nettype wire

//--- sim/tcu_far_end.sv
// far side of the timer: generic clock ticks, count events and pins
// assumes the bench calls its tasks; everything moves on rising edges
`default_nettype none
module tcu_far_end (
    // clock and control
    input wire logic clk_i,
    input wire logic run_i,
    // sources seen by the timer
    output logic gclk_tick_o,
    output logic count_evt_o,
    output logic cap_evt_o,
    output logic [1:0] cap_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        count_evt_o = 1'h0;
        cap_evt_o = 1'h0;
        cap_pin_o = 2'h0;
    end
    // the generic clock ticks every cycle while running
    assign gclk_tick_o = run_i;
    task automatic pulse_count();
        @(posedge clk_i);
        count_evt_o <= 1'h1;
        @(posedge clk_i);
        count_evt_o <= 1'h0;
    endtask
    task automatic pulse_cap();
        @(posedge clk_i);
        cap_evt_o <= 1'h1;
        @(posedge clk_i);
        cap_evt_o <= 1'h0;
    endtask
    task automatic set_pin(input logic [1:0] v);
        @(posedge clk_i);
        cap_pin_o <= v;
    endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the timer/counter
// assumes tcu_pkg and tcu_top compiled first
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic enable_i = 1'h0;
    logic cfg_wr_i = 1'h0;
    logic perb_wr_i = 1'h0;
    logic run = 1'h1;
    logic [1:0] ccb_wr_i = 2'h0;
    logic [31:0] ccb_data_i = 32'h0;
    logic [7:0] perb_data_i = 8'h0;
    tcu_pkg::tcu_cfg_s cfg_i = '0;
    tcu_pkg::tcu_cfg_s c;
    tcu_pkg::tcu_req_s ovf_en_i = 3'h5;
    tcu_pkg::tcu_req_s mc0_en_i = 3'h7;
    tcu_pkg::tcu_req_s mc1_en_i = 3'h3;
    tcu_pkg::tcu_req_s ovf_o, mc0_o, mc1_o;
    logic gclk, cevt, capev;
    logic [1:0] pins, bfv, wave, capture;
    logic [31:0] count, cc0, cc1;
    logic [7:0] period_value;
    logic perv;
    int errors = 0;
    int comparisons = 0;
    int len, hits;
    always #25 clk_i = ~clk_i;
    tcu_far_end u_tcu_far_end (.clk_i(clk_i), .run_i(run),
        .gclk_tick_o(gclk), .count_evt_o(cevt), .cap_evt_o(capev),
        .cap_pin_o(pins));
    tcu_top u_tcu_top (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .enable_i(enable_i), .cfg_wr_i(cfg_wr_i), .cfg_i(cfg_i),
        .ovf_en_i(ovf_en_i), .mc0_en_i(mc0_en_i), .mc1_en_i(mc1_en_i),
        .ccb_wr_i(ccb_wr_i), .ccb_data_i(ccb_data_i),
        .perb_wr_i(perb_wr_i), .perb_data_i(perb_data_i),
        .gclk_tick_i(gclk), .count_evt_i(cevt), .cap_evt_i(capev),
        .cap_pin_i(pins), .count_o(count), .cc0_o(cc0), .cc1_o(cc1),
        .buffer_valid_flag_o(bfv), .period_value_o(period_value),
        .period_valid_o(perv), .wave_o(wave), .ovf_req_o(ovf_o),
        .mc0_req_o(mc0_o), .mc1_req_o(mc1_o), .capture_o(capture));
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // sample just after the edge so registered outputs have settled
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        rst_b_i <= 1'h0;
        enable_i <= 1'h0;
        run <= 1'h1;
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'h1;
        #1;
    endtask
    task automatic wcfg(input tcu_pkg::tcu_cfg_s v);
        @(posedge clk_i);
        cfg_i <= v;
        cfg_wr_i <= 1'h1;
        @(posedge clk_i);
        cfg_wr_i <= 1'h0;
        #1;
    endtask
    task automatic wbuf(input logic [1:0] ch, input logic [31:0] d,
        input logic pw, input logic [7:0] pd);
        @(posedge clk_i);
        ccb_data_i <= d;
        ccb_wr_i <= ch;
        perb_data_i <= pd;
        perb_wr_i <= pw;
        @(posedge clk_i);
        ccb_wr_i <= 2'h0;
        perb_wr_i <= 1'h0;
        #1;
    endtask
    task automatic go();
        @(posedge clk_i);
        enable_i <= 1'h1;
    endtask
    // which 0 waits for an overflow pulse, 1 for a channel zero capture
    task automatic wait_sig(input int which);
        for (int i = 0; i < 400; i++)
        begin
            cyc(1);
            if ((which == 0 ? |ovf_o : capture[0]) === 1'h1)
                return;
        end
        errors++;
        end_of_test();
    endtask
    // cycles from one overflow to the next, counting channel one matches
    task automatic per_len();
        len = 0;
        hits = 0;
        repeat (20)
        begin
            cyc(1);
            len++;
            if ((|mc1_o) === 1'h1)
            begin
                hits++;
                chk("mc1 req", mc1_o, mc1_en_i);
                chk("mc1 count", count, 32'h2);
            end
            if ((|ovf_o) === 1'h1)
                return;
        end
        errors++;
        end_of_test();
    endtask
    initial
    begin
        do_reset();
        chk("count", count, 32'h0);
        chk("period", period_value, 32'hff);
        chk("flags", {perv, bfv}, 32'h0);
        c = '0;
        c.counter_width_select = tcu_pkg::TCU_W8;
        wcfg(c);
        wbuf(2'h3, 32'h1, 1'h1, 8'h02);
        chk("flags set", {perv, bfv}, 32'h7);
        go();
        wait_sig(0);
        chk("ovf req", ovf_o, ovf_en_i);
        chk("wrap", count, 32'h0);
        chk("period copy", period_value, 32'h2);
        chk("cc1 copy", cc1, 32'h1);
        chk("flags clear", {perv, bfv}, 32'h0);
        per_len();
        chk("period len", len, 32'h3);
        chk("mc1 hits", hits, 32'h1);
        c.count_down = 1'h1;
        wcfg(c);
        wait_sig(0);
        chk("locked wrap", count, 32'h0);
        per_len();
        chk("locked len", len, 32'h3);
        cyc(1);
        chk("still up", count, 32'h1);
        do_reset();
        c = '0;
        c.count_down = 1'h1;
        c.clk_evt = 1'h1;
        wcfg(c);
        go();
        cyc(4);
        chk("no event", count, 32'h0);
        u_tcu_far_end.pulse_count();
        #1;
        chk("underflow", count, 32'hffff);
        chk("unf req", ovf_o, ovf_en_i);
        u_tcu_far_end.pulse_count();
        #1;
        chk("down", count, 32'hfffe);
        do_reset();
        c = '0;
        c.cap_en = 2'h3;
        c.cap_fall = 2'h2;
        wcfg(c);
        go();
        cyc(10);
        u_tcu_far_end.set_pin(2'h1);
        wait_sig(1);
        chk("capture", cc0, 32'ha);
        chk("cap pulse", capture, 32'h1);
        chk("cap req", mc0_o, mc0_en_i);
        u_tcu_far_end.set_pin(2'h2);
        cyc(1);
        chk("wrong edge", capture, 32'h0);
        u_tcu_far_end.set_pin(2'h0);
        cyc(1);
        chk("fall capture", cc1, 32'he);
        chk("fall pulse", capture, 32'h2);
        @(posedge clk_i);
        run <= 1'h0;
        cyc(3);
        chk("no tick", count, 32'h10);
        // match-frequency, 32-bit, prescaler dividing by two
        do_reset();
        c = '0;
        c.counter_width_select = tcu_pkg::TCU_W32;
        c.wave = tcu_pkg::TCU_MFRQ;
        c.psc = 3'h1;
        wcfg(c);
        wbuf(2'h1, 32'h3, 1'h0, 8'h00);
        wbuf(2'h2, 32'h1, 1'h0, 8'h00);
        go();
        wait_sig(0);
        chk("mfrq set", wave, 32'h1);
        chk("cc0 top", cc0, 32'h3);
        per_len();
        chk("mfrq len", len, 32'h8);
        chk("mfrq hits", hits, 32'h1);
        chk("mfrq clear", wave, 32'h0);
        // single-slope pwm, 8-bit, channel one captures on event
        do_reset();
        c = '0;
        c.counter_width_select = tcu_pkg::TCU_W8;
        c.wave = tcu_pkg::TCU_NPWM;
        c.cap_en = 2'h2;
        c.cap_evt = 2'h2;
        wcfg(c);
        wbuf(2'h1, 32'h2, 1'h1, 8'h03);
        go();
        wait_sig(0);
        chk("pwm high", wave[0], 32'h1);
        cyc(2);
        chk("pwm low", wave[0], 32'h0);
        u_tcu_far_end.pulse_cap();
        #1;
        chk("evt capture", cc1, 32'h3);
        chk("evt pulse", capture, 32'h2);
        chk("evt req", mc1_o, mc1_en_i);
        chk("pwm wrap", wave[0], 32'h1);
        end_of_test();
    end
endmodule
`default_nettype wire
